// file: logic/mwp_area_check.sv
/*
  Area check: decides whether one write or erase request may proceed.
  Assumes the guard bits are stable while the request is looked at.
*/
`timescale 1ns/100ps
`default_nettype none

module mwp_area_check (
  input  wire mwp_pkg::mwp_wreq_t  req_i,
  input  wire mwp_pkg::mwp_guard_t guard_i,
  output var  logic                allow_o
);
  import mwp_pkg::*;

  // ----------------------------------------------------------------------
  // Block hits
  // ----------------------------------------------------------------------
  wire [BLOCK_CNT-1:0] blk_hit;
  wire [BLOCK_CNT-1:0] blk_locked;

  genvar n;
  generate
    for (n = 0; n < BLOCK_CNT; n++) begin : g_blk
      localparam logic [21:0] LO = (n == 0) ? BLK0_LO : BLK_SIZE * 22'(n);
      localparam logic [21:0] HI = BLK_SIZE * 22'(n) + BLK_SIZE - 22'h000001;
      assign blk_hit[n]    = (req_i.addr >= LO) && (req_i.addr <= HI);
      assign blk_locked[n] = blk_hit[n] && !guard_i.block_write_guard[n]; // [R1] [R2]
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Other areas
  // ----------------------------------------------------------------------
  wire boot_hit = (req_i.addr >= BOOT_LO) && (req_i.addr <= BOOT_HI);
  wire cfg_hit  = (req_i.addr >= CFG_LO) && (req_i.addr <= CFG_HI);

  // EEPROM has its own address space, so the address is ignored there
  wire ee_locked   = !guard_i.eeprom_write_guard; // [R3]
  wire prog_locked = (|blk_locked)
                   || (boot_hit && !guard_i.boot_area_write_guard)
                   || (cfg_hit && !guard_i.config_space_write_guard);

  assign allow_o = req_i.eeprom ? !ee_locked : !prog_locked;

endmodule : mwp_area_check

`default_nettype wire

// file: logic/mwp_pkg.sv
/*
  Package for the memory write-protect configuration block: register
  offsets, field positions, unprogrammed values, area bounds and carriers.
  Assumes a byte-wide configuration port and 22-bit byte addresses.
*/
//
// Contract
// [R1] Bits 3..0 of the low protect byte guard program blocks 0..3, a 1 leaving the block writable.
// [R2] With a block's guard at 0, every write or erase aimed inside that block is refused.
// [R3] Bit 7 of the high protect byte guards the data EEPROM, a 0 blocking every EEPROM write.
// [R4] Bits 7..4 of the low byte and bits 4..0 of the high byte always read zero.
// [R5] Guards read 1 when unprogrammed and keep their programmed value through any reset.
// [R6] The block guards sit in the byte at 30000Ah, readable and programmable.
// [R7] The byte at 30000Bh holds the EEPROM, boot area and configuration space guards, each 1 unprogrammed.
// [R8] The configuration space guard changes only in external programming mode, never from user code.
`default_nettype none

package mwp_pkg;

  // ----------------------------------------------------------------------
  // Widths and register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W         = 22;
  localparam int          DATA_W         = 8;
  localparam int          BLOCK_CNT      = 4;
  localparam logic [21:0] PROT_LOW_OFS   = 22'h30000A;
  localparam logic [21:0] PROT_HIGH_OFS  = 22'h30000B;

  // ----------------------------------------------------------------------
  // Field positions, read-zero value and unprogrammed values
  // ----------------------------------------------------------------------
  localparam int          BLOCK_LSB      = 0;
  localparam int          EEPROM_BIT     = 7;
  localparam int          BOOT_BIT       = 6;
  localparam int          CFG_BIT        = 5;
  localparam logic        UNPROG_VAL     = 1'b1;
  localparam logic [7:0]  RD_ZERO        = 8'h00;

  // ----------------------------------------------------------------------
  // Protected areas
  // ----------------------------------------------------------------------
  localparam logic [21:0] BOOT_LO        = 22'h000000;
  localparam logic [21:0] BOOT_HI        = 22'h0001FF;
  localparam logic [21:0] BLK0_LO        = 22'h000200;
  localparam logic [21:0] BLK_SIZE       = 22'h002000;
  localparam logic [21:0] CFG_LO         = 22'h300000;
  localparam logic [21:0] CFG_HI         = 22'h3000FF;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 eeprom_write_guard;
    logic                 boot_area_write_guard;
    logic                 config_space_write_guard;
    logic [BLOCK_CNT-1:0] block_write_guard;
  } mwp_guard_t;

  typedef struct packed {
    logic              valid;
    logic              eeprom;
    logic [ADDR_W-1:0] addr;
  } mwp_wreq_t;

endpackage : mwp_pkg

`default_nettype wire

// file: logic/mwp_top.sv
/*
  Memory write-protect configuration: two nonvolatile protect bytes, a
  byte-wide configuration port and a grant/deny answer for write sequencers.
  Assumes strobes are one cycle, synchronous, and never both high at once.
*/
`timescale 1ns/100ps
`default_nettype none

module mwp_top (
  input  wire logic                      clock_i,
  input  wire logic                      arst_n_i,
  input  wire logic [mwp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [mwp_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output var  logic [mwp_pkg::DATA_W-1:0] rdata_o,
  output var  logic                      wr_refused_o,
  input  wire logic                      prog_mode_i,
  input  wire logic                      bulk_erase_i,
  input  wire mwp_pkg::mwp_wreq_t         wreq_i,
  output var  logic                      grant_o,
  output var  logic                      deny_o,
  output var  mwp_pkg::mwp_guard_t        guard_o
);
  import mwp_pkg::*;

  // ----------------------------------------------------------------------
  // Nonvolatile guard cells
  // ----------------------------------------------------------------------
  // Cells have no reset on purpose: they model stored bits, which a
  // device reset must leave alone. Power-up shows the erased pattern.
  mwp_guard_t nv_reg = '{UNPROG_VAL, UNPROG_VAL, UNPROG_VAL, {BLOCK_CNT{UNPROG_VAL}}}; // [R5]
  mwp_guard_t nv_next;

  // ----------------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------------
  wire low_sel   = (addr_i == PROT_LOW_OFS);  // [R6]
  wire high_sel  = (addr_i == PROT_HIGH_OFS); // [R7]
  wire cfg_open  = nv_reg.config_space_write_guard;
  wire erase_go  = prog_mode_i && bulk_erase_i;
  // Config bytes live in config space, so its own guard locks them too
  wire wr_low    = wr_i && low_sel && cfg_open;
  wire wr_high   = wr_i && high_sel && cfg_open;
  wire wr_refuse = wr_i && (low_sel || high_sel) && !cfg_open && !erase_go;

  wire [DATA_W-1:0] low_view  = {4'h0, nv_reg.block_write_guard}; // [R4]
  wire [DATA_W-1:0] high_view = {nv_reg.eeprom_write_guard,
                                 nv_reg.boot_area_write_guard,
                                 nv_reg.config_space_write_guard,
                                 5'h00};                          // [R4]
  wire [DATA_W-1:0] rd_mux    = !rd_i     ? RD_ZERO :
                                low_sel   ? low_view :
                                high_sel  ? high_view : RD_ZERO;

  // ----------------------------------------------------------------------
  // Next guard value
  // ----------------------------------------------------------------------
  always_comb begin
    nv_next = nv_reg;
    if (erase_go) begin
      nv_next = '{UNPROG_VAL, UNPROG_VAL, UNPROG_VAL, {BLOCK_CNT{UNPROG_VAL}}}; // [R5]
    end else if (wr_low) begin
      nv_next.block_write_guard = wdata_i[BLOCK_LSB +: BLOCK_CNT]; // [R1] [R6]
    end else if (wr_high) begin
      nv_next.eeprom_write_guard    = wdata_i[EEPROM_BIT]; // [R3] [R7]
      nv_next.boot_area_write_guard = wdata_i[BOOT_BIT];   // [R7]
      if (prog_mode_i) begin
        nv_next.config_space_write_guard = wdata_i[CFG_BIT]; // [R8]
      end
    end
  end

  always_ff @(posedge clock_i) begin
    nv_reg <= nv_next;
  end

  // ----------------------------------------------------------------------
  // Request check
  // ----------------------------------------------------------------------
  logic allow;

  mwp_area_check u_check (
    .req_i   (wreq_i),
    .guard_i (nv_reg),
    .allow_o (allow)
  );

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_reg;
  logic              refused_reg;
  logic              grant_reg;
  logic              deny_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg   <= RD_ZERO;
      refused_reg <= 1'b0;
      grant_reg   <= 1'b0;
      deny_reg    <= 1'b0;
    end else begin
      rdata_reg   <= rd_mux;
      refused_reg <= wr_refuse;
      grant_reg   <= wreq_i.valid && allow;  // [R2] [R3]
      deny_reg    <= wreq_i.valid && !allow; // [R2] [R3]
    end
  end

  assign rdata_o      = rdata_reg;
  assign wr_refused_o = refused_reg;
  assign grant_o      = grant_reg;
  assign deny_o       = deny_reg;
  assign guard_o      = nv_reg;

endmodule : mwp_top

`default_nettype wire

// file: verification/memory_write_protect_config_tb_top.sv
/* Bench for mwp_top: table of guard settings and requests, then reset, lock and erase cases.
   Assumes the sequencer model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module memory_write_protect_config_tb_top;
  import mwp_pkg::*;
  typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic ee; logic [21:0] a; logic ok;} mwp_row_t;
  logic clock_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, pm = 1'b0, be = 1'b0, go = 1'b0, ee = 1'b0;
  logic grant, deny, refused;
  logic [21:0] addr = '0, ra = '0;
  logic [7:0] wd = '0, rdata, commits;
  mwp_wreq_t wreq;
  mwp_guard_t guard;
  int err_count = 0, n_compared = 0, cyc = 0;
  // Bits 4..0 of the high byte and, in all rows but the last, 7..4 of the low one set, to see them read back zero
  mwp_row_t rows [8] = '{'{8'hFF,8'hFF,1'b0,22'h006000,1'b1}, '{8'hF7,8'hFF,1'b0,22'h007FFF,1'b0},
    '{8'hFB,8'hFF,1'b0,22'h004000,1'b0}, '{8'hFD,8'hFF,1'b0,22'h003FFF,1'b0},
    '{8'hFE,8'hFF,1'b0,22'h000200,1'b0}, '{8'hFE,8'hBF,1'b0,22'h0001FF,1'b0},
    '{8'hFF,8'h7F,1'b1,22'h000000,1'b0}, '{8'h00,8'hFF,1'b1,22'h008000,1'b1}};
  always #5 clock_i = ~clock_i;
  mwp_top DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .wr_refused_o(refused), .prog_mode_i(pm), .bulk_erase_i(be), .wreq_i(wreq),
    .grant_o(grant), .deny_o(deny), .guard_o(guard));
  mwp_seq_model u_seq (.clock_i(clock_i), .go_i(go), .ee_i(ee), .addr_i(ra), .grant_i(grant), .wreq_o(wreq),
    .commits_o(commits));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [21:0] a, input logic [7:0] d, input logic p, input logic b);
    @(posedge clock_i);
    addr <= a;
    wd   <= d;
    pm   <= p;
    be   <= b;
    wr   <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    pm <= 1'b0;
    be <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [21:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask : rd_reg
  task automatic req(input logic e1, input logic [21:0] a, input logic ok);
    @(posedge clock_i);
    go <= 1'b1;
    ee <= e1;
    ra <= a;
    @(posedge clock_i);
    go <= 1'b0;
    #1;
    chk("grant", {7'h00, grant}, {7'h00, ok});
    chk("deny", {7'h00, deny}, {7'h00, !ok});
  endtask : req
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Run takes a little over a hundred cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd_reg(PROT_LOW_OFS, 8'h0F);
    rd_reg(PROT_HIGH_OFS, 8'hE0);
    rd_reg(22'h300009, 8'h00);
    foreach (rows[i]) begin
      wr_reg(PROT_LOW_OFS, rows[i].lo, 1'b0, 1'b0);
      wr_reg(PROT_HIGH_OFS, rows[i].hi, 1'b0, 1'b0);
      rd_reg(PROT_LOW_OFS, rows[i].lo & 8'h0F);
      rd_reg(PROT_HIGH_OFS, (rows[i].hi & 8'hC0) | 8'h20);
      req(rows[i].ee, rows[i].a, rows[i].ok);
    end
    // Model commits on the edge after the grant pulse, so wait one more edge
    @(posedge clock_i);
    #1;
    chk("commits", commits, 8'h02);
    arst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd_reg(PROT_LOW_OFS, 8'h00);
    wr_reg(PROT_HIGH_OFS, 8'hDF, 1'b0, 1'b0);
    rd_reg(PROT_HIGH_OFS, 8'hE0);
    wr_reg(PROT_HIGH_OFS, 8'hDF, 1'b1, 1'b0);
    rd_reg(PROT_HIGH_OFS, 8'hC0);
    req(1'b0, 22'h300000, 1'b0);
    wr_reg(PROT_LOW_OFS, 8'h0F, 1'b0, 1'b0);
    chk("refused", {7'h00, refused}, 8'h01);
    rd_reg(PROT_LOW_OFS, 8'h00);
    wr_reg(22'h000000, 8'h00, 1'b1, 1'b1);
    chk("guard", {1'b0, guard}, 8'h7F);
    finish_test();
  end
endmodule : memory_write_protect_config_tb_top
`default_nettype wire

// file: verification/mwp_seq_model.sv
/* Write sequencer model: turns bench commands into requests, commits on grant.
   Assumes the answer comes one cycle after the request. */
`timescale 1ns/100ps
`default_nettype none
module mwp_seq_model (
  input  wire logic               clock_i,
  input  wire logic               go_i,
  input  wire logic               ee_i,
  input  wire logic [21:0]        addr_i,
  input  wire logic               grant_i,
  output var  mwp_pkg::mwp_wreq_t wreq_o,
  output var  logic [7:0]         commits_o
);
  import mwp_pkg::*;
  assign wreq_o = '{valid: go_i, eeprom: ee_i, addr: addr_i};
  initial commits_o = 8'h00;
  // Commit only when granted, so a denied write leaves storage alone
  always @(posedge clock_i) begin
    if (grant_i) begin
      commits_o <= commits_o + 8'h01;
    end
  end
endmodule : mwp_seq_model
`default_nettype wire

// file: verification/mwp_top_asserts.sv
/* Checker on the mwp_top ports: read map, request answers and guard retention.
   Assumes strobes and requests stay low while reset is held. */
`timescale 1ns/100ps
`default_nettype none
module mwp_top_chk
  import mwp_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              arst_n_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic              prog_mode_i,
  input wire logic              bulk_erase_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              wr_refused_o,
  input wire logic              grant_o,
  input wire logic              deny_o,
  input wire mwp_wreq_t         wreq_i,
  input wire mwp_guard_t        guard_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire logic       in_blk = wreq_i.addr >= BLK0_LO && wreq_i.addr < 22'h008000;
  wire logic [1:0] blk    = wreq_i.addr[14:13];
  a_low_read_map: assert property ($past(rd_i) && $past(addr_i) == PROT_LOW_OFS |->
    rdata_o == {4'h0, $past(guard_o.block_write_guard)}) else $error("low byte read");
  a_high_read_map: assert property ($past(rd_i) && $past(addr_i) == PROT_HIGH_OFS |->
    rdata_o == {$past(guard_o[6:4]), 5'h00}) else $error("high byte read");
  a_one_answer: assert property ((grant_o || deny_o) == $past(wreq_i.valid) && !(grant_o && deny_o))
    else $error("request answer");
  a_eeprom_deny: assert property (wreq_i.valid && wreq_i.eeprom && !guard_o.eeprom_write_guard |=> deny_o)
    else $error("eeprom not denied");
  a_block_deny: assert property (wreq_i.valid && !wreq_i.eeprom && in_blk && !guard_o.block_write_guard[blk]
    |=> deny_o) else $error("block not denied");
  // Guards live outside reset, so this one ignores it
  a_guard_kept: assert property (disable iff (1'b0) !arst_n_i |=> $stable(guard_o)) else $error("guard lost");
  a_locked_write: assert property (wr_i && !guard_o.config_space_write_guard && !bulk_erase_i &&
    addr_i[21:1] == PROT_LOW_OFS[21:1] |=> wr_refused_o && $stable(guard_o)) else $error("locked write");
  a_low_write: assert property (wr_i && guard_o.config_space_write_guard && !prog_mode_i &&
    addr_i == PROT_LOW_OFS |=> guard_o.block_write_guard == $past(wdata_i[3:0])) else $error("low write");
  c_deny: cover property (deny_o);
  c_grant: cover property (grant_o);
  c_refused: cover property (wr_refused_o);
  c_erase: cover property (prog_mode_i && bulk_erase_i);
endmodule : mwp_top_chk
bind mwp_top mwp_top_chk u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .wr_i(wr_i), .rd_i(rd_i),
  .prog_mode_i(prog_mode_i), .bulk_erase_i(bulk_erase_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .wr_refused_o(wr_refused_o), .grant_o(grant_o), .deny_o(deny_o), .wreq_i(wreq_i), .guard_o(guard_o));
`default_nettype wire
